// file: rtl/ccs_consts.svh
// constants for the compact clock source and divider controller
//
// Overview of operation
// [R1] sub clock source field bits 5-4: hf, lf, ext, code 11 means lf.
// [R2] main clock source field bits 1-0, same coding, 11 falls back to lf.
// [R3] aux divider bits 10-8: powers of two 1..32, codes 110/111 give 32.
// [R4] sub divider bits 6-4: powers of two 1..32, reserved codes give 32.
// [R5] main divider bits 2-0: same power-of-two coding, reserved codes give 32.
// [R6] crystal runs when disable bit 0 clear; when set, stops unless sourcing a clock.
// [R7] crystal fault flag bit 1 set whenever the crystal fault is present.
// [R8] hf oscillator fault flag bit 0 set whenever that fault is present.
// [R9] oscillator fault interrupt flag follows either fault flag.
// [R10] software clears crystal fault flag; stays set while fault persists.
// [R11] software clears hf fault flag; stays set while fault persists.
// [R12] sub request enable bit 2: low-power off unless enabled and requested.
// [R13] main request enable bit 1: low-power off unless enabled and requested.
// [R14] aux request enable bit 0: low-power off unless enabled and requested.
// [R15] reserved bits read zero and ignore writes.
// [R16] aux clock source field bits 9-8: hf, lf, ext.
// [R17] key A5h unlocks writes; wrong word key or locked write issues power-up clear.
// [R18] peripheral request overrides clock-off without changing the stored off bit.
// [R19] no hf transition for five lf cycles moves hf-sourced trees to lf.
// [R20] source and divider changes cause no runt pulse on output clocks; here only divider changes wait for output low, the source mux switches at once.
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

`define CCS_OFS_KEY      12'h000
`define CCS_OFS_SRC      12'h008
`define CCS_OFS_DIV      12'h00C
`define CCS_OFS_XOFF     12'h010
`define CCS_OFS_FAULT    12'h014
`define CCS_OFS_REQ      12'h018
`define CCS_KEY_VALUE    8'hA5
`define CCS_KEY_READ     8'h96
`define CCS_SRC_RESET    16'h0100
`define CCS_DIV_RESET    16'h0333
`define CCS_XOFF_RESET   16'h0001
`define CCS_FAULT_RESET  16'h0003
`define CCS_REQ_RESET    16'h0007
`define CCS_SRC_MASK     16'h0333
`define CCS_DIV_MASK     16'h0777
`define CCS_XOFF_MASK    16'h0001
`define CCS_FAULT_MASK   16'h0003
`define CCS_REQ_MASK     16'h0007
`define CCS_HF_TIMEOUT   3'h5

`endif

// file: rtl/ccs_pkg.sv
// types for the compact clock source and divider controller
package ccs_pkg;
  typedef struct packed {
    logic aux;
    logic main;
    logic sub;
  } ccs_trio_s;
endpackage

// file: rtl/ccs_clock_ctrl.sv
// compact clock source selection, division, gating and fault control
`timescale 1ns/1ns
`default_nettype none
`include "ccs_consts.svh"
module ccs_clock_ctrl (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  // oscillator clock levels and fault conditions from outside
  input  wire logic             high_freq_clock,
  input  wire logic             low_freq_clock,
  input  wire logic             external_clock_input,
  input  wire logic             crystal_fault,
  input  wire logic             high_freq_oscillator_fault,
  // low-power clock-off controls and peripheral requests
  input  wire ccs_pkg::ccs_trio_s clock_off,
  input  wire ccs_pkg::ccs_trio_s clock_request,
  // generated clocks and status
  output ccs_pkg::ccs_trio_s    clock_out,
  output logic                  crystal_enable,
  output logic                  osc_fault_irq_flag,
  output logic                  power_up_clear
);

  // input synchronisers, two flops each
  logic [10:0] sync1;
  logic [10:0] sync2;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
    end else begin
      sync1 <= {high_freq_clock, low_freq_clock, external_clock_input, crystal_fault,
                high_freq_oscillator_fault, clock_off, clock_request};
      sync2 <= sync1;
    end
  end
  wire       hf_s    = sync2[10];
  wire       lf_s    = sync2[9];
  wire       ext_s   = sync2[8];
  wire       xflt_s  = sync2[7];
  wire       hflt_s  = sync2[6];
  wire [2:0] off_s   = sync2[5:3];
  wire [2:0] req_s   = sync2[2:0];

  // registers
  logic        unlocked;
  logic [15:0] src_sel;
  logic [15:0] div_sel;
  logic [15:0] xoff;
  logic [15:0] fault;
  logic [15:0] req_en;

  // apb decode
  wire        acc     = psel && penable;
  // a write lands once, at the edge that samples pready high
  wire        wr      = acc && pwrite && pready;
  wire        hit_key = paddr == `CCS_OFS_KEY;
  wire        hit_src = paddr == `CCS_OFS_SRC;
  wire        hit_div = paddr == `CCS_OFS_DIV;
  wire        hit_xo  = paddr == `CCS_OFS_XOFF;
  wire        hit_flt = paddr == `CCS_OFS_FAULT;
  wire        hit_req = paddr == `CCS_OFS_REQ;
  wire        mapped  = hit_key | hit_src | hit_div | hit_xo | hit_flt | hit_req;
  wire        key_hi  = pstrb[1];
  wire        key_ok  = pwdata[15:8] == `CCS_KEY_VALUE;
  wire        word_wr = pstrb[1] && pstrb[0];
  wire        cfg_hit = hit_src | hit_div | hit_xo | hit_flt | hit_req;
  wire        can_wr  = wr && unlocked;
  // wrong key as a word, or locked write elsewhere, resets the system
  wire        puc_evt = wr && ((hit_key && word_wr && !key_ok) ||
                               (cfg_hit && !unlocked)); // see [R17]
  wire [15:0] be_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] next_src = (src_sel & ~be_mask) | (pwdata[15:0] & be_mask & `CCS_SRC_MASK);
  wire [15:0] next_div = (div_sel & ~be_mask) | (pwdata[15:0] & be_mask & `CCS_DIV_MASK);
  wire [15:0] next_xo  = (xoff & ~be_mask) | (pwdata[15:0] & be_mask & `CCS_XOFF_MASK);
  wire [15:0] next_req = (req_en & ~be_mask) | (pwdata[15:0] & be_mask & `CCS_REQ_MASK);
  // write one to keep, zero clears; the live fault sets and wins
  wire [15:0] flt_clr  = be_mask & ~pwdata[15:0] & {16{can_wr && hit_flt}};
  wire [15:0] next_flt = ((fault & ~flt_clr) | {14'h0000, xflt_s, hflt_s})
                         & `CCS_FAULT_MASK; // see [R7] [R8] [R10] [R11]
  wire [15:0] rd_key  = {`CCS_KEY_READ, 8'h00};
  wire [15:0] rd_val  = hit_key ? rd_key : hit_src ? src_sel : hit_div ? div_sel :
                        hit_xo ? xoff : hit_flt ? fault : hit_req ? req_en : 16'h0000;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      unlocked <= 1'b0;
      src_sel  <= `CCS_SRC_RESET;
      div_sel  <= `CCS_DIV_RESET;
      xoff     <= `CCS_XOFF_RESET;
      fault    <= `CCS_FAULT_RESET;
      req_en   <= `CCS_REQ_RESET;
    end else if (puc_evt) begin
      unlocked <= 1'b0;
      src_sel  <= `CCS_SRC_RESET;
      div_sel  <= `CCS_DIV_RESET;
      xoff     <= `CCS_XOFF_RESET;
      fault    <= `CCS_FAULT_RESET;
      req_en   <= `CCS_REQ_RESET;
    end else begin
      if (wr && hit_key && key_hi) begin
        unlocked <= key_ok; // see [R17]
      end
      if (can_wr && hit_src) begin
        src_sel <= next_src; // see [R15]
      end
      if (can_wr && hit_div) begin
        div_sel <= next_div; // see [R15]
      end
      if (can_wr && hit_xo) begin
        xoff <= next_xo;
      end
      if (can_wr && hit_req) begin
        req_en <= next_req;
      end
      fault <= next_flt;
    end
  end

  // apb answer registered: one wait state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      prdata  <= (acc && !pready && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
      pslverr <= acc && !pready && !mapped;
    end
  end

  // hf watchdog: counts lf rising edges without an hf edge
  logic       hf_d;
  logic       lf_d;
  logic [2:0] hf_cnt;
  logic       hf_dead;
  wire        hf_edge = hf_s ^ hf_d;
  wire        lf_rise = lf_s && !lf_d;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hf_d    <= 1'b0;
      lf_d    <= 1'b0;
      hf_cnt  <= 3'h0;
      hf_dead <= 1'b0;
    end else begin
      hf_d <= hf_s;
      lf_d <= lf_s;
      if (hf_edge) begin
        hf_cnt  <= 3'h0;
        hf_dead <= 1'b0;
      end else if (lf_rise && hf_cnt != `CCS_HF_TIMEOUT) begin
        hf_cnt <= hf_cnt + 3'h1;
      end else if (hf_cnt == `CCS_HF_TIMEOUT) begin
        hf_dead <= 1'b1; // see [R19]
      end
    end
  end

  // per-tree source, divider and gating; index 0 aux, 1 main, 2 sub
  wire [1:0] sel_f [3];
  wire [2:0] div_f [3];
  assign sel_f[0] = src_sel[9:8];   // see [R16]
  assign sel_f[1] = src_sel[1:0];   // see [R2]
  assign sel_f[2] = src_sel[5:4];   // see [R1]
  assign div_f[0] = div_sel[10:8];  // see [R3]
  assign div_f[1] = div_sel[2:0];   // see [R5]
  assign div_f[2] = div_sel[6:4];   // see [R4]
  wire [2:0] uses_ext;
  wire [2:0] clk_q;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tree
      // reserved code and dead hf both fall to lf
      wire       src_lvl = (sel_f[g] == 2'h0) ? (hf_dead ? lf_s : hf_s) :
                           (sel_f[g] == 2'h2) ? ext_s : lf_s; // see [R19]
      logic      src_d;
      logic [4:0] cnt;
      logic      q;
      logic [2:0] div_act;
      wire [2:0] div_lim = (div_f[g] > 3'h5) ? 3'h5 : div_f[g];
      wire [4:0] half    = 5'(({4'h0, 1'b1} << div_act) - 5'h1);
      wire       rise    = src_lvl && !src_d;
      wire       fall    = !src_lvl && src_d;
      // request enable plus a live request overrides the off control
      // struct bits run msb aux to lsb sub, tree index runs aux first
      wire       run     = !off_s[2 - g] || (req_en[g] && req_s[2 - g]); // see [R12] [R13] [R14] [R18]
      assign uses_ext[g] = sel_f[g] == 2'h2;
      assign clk_q[g]    = q;
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          src_d   <= 1'b0;
          cnt     <= 5'h00;
          q       <= 1'b0;
          div_act <= 3'h3;
        end else begin
          src_d <= src_lvl;
          if (div_act == 3'h0) begin
            q <= src_lvl && run;
            if (!q && !src_lvl) begin
              div_act <= div_lim;
            end
          end else if (rise || fall) begin
            if (cnt == half) begin
              cnt <= 5'h00;
              q   <= !q && run;
              // ratio changes only take hold with the output low, after a full half
              if (q || !run) begin
                div_act <= div_lim; // see [R20]
              end
            end else begin
              cnt <= cnt + 5'h01;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clock_out          <= '0;
      crystal_enable     <= 1'b0;
      osc_fault_irq_flag <= 1'b0;
      power_up_clear     <= 1'b0;
    end else begin
      clock_out          <= {clk_q[0], clk_q[1], clk_q[2]};
      crystal_enable     <= !xoff[0] || (|uses_ext); // see [R6]
      osc_fault_irq_flag <= |fault[1:0]; // see [R9]
      power_up_clear     <= puc_evt; // see [R17]
    end
  end

endmodule
`default_nettype wire

// file: test/ccs_clock_ctrl_asserts.sv
// port assertions for the clock controller
`timescale 1ns/1ns
`default_nettype none
module ccs_clock_ctrl_asserts (
  // watched ports
  input wire logic core_clk, nrst, psel, penable, pwrite, pready, pslverr,
  input wire logic crystal_fault, high_freq_oscillator_fault, osc_fault_irq_flag, power_up_clear,
  input wire logic [31:0] prdata,
  input wire ccs_pkg::ccs_trio_s clock_off, clock_request, clock_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] fc;
  logic [3:0] hc;
  wire halt = &(clock_off & ~clock_request);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fc <= 4'h0;
      hc <= 4'h0;
    end else begin
      fc <= (crystal_fault | high_freq_oscillator_fault) ? fc + {3'h0, fc != 4'hF} : 4'h0;
      hc <= halt ? hc + {3'h0, hc != 4'hF} : 4'h0;
    end
  end
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_READY_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready late");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("stray error");
  AST_RDATA_ZERO: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("stray read data");
  AST_PUC_ONE: assert property (power_up_clear |=> !power_up_clear)
    else $error("clear too long");
  AST_PUC_CAUSE: assert property (
    power_up_clear |-> $past(pwrite && penable) || $past(pwrite && penable, 2))
    else $error("clear without write");
  AST_FAULT_IRQ: assert property (fc > 4'h5 |-> osc_fault_irq_flag)
    else $error("fault flag missing");
  AST_HALT: assert property (hc > 4'h6 |-> $stable(clock_out))
    else $error("halted clock moves");
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_asserts u_asserts (.core_clk, .nrst, .psel, .penable,
  .pwrite, .pready, .pslverr, .crystal_fault, .high_freq_oscillator_fault, .osc_fault_irq_flag,
  .power_up_clear, .prdata, .clock_off, .clock_request, .clock_out);
`default_nettype wire

// file: test/ccs_osc_model.sv
// oscillator clock model for the clock controller
`timescale 1ns/1ns
`default_nettype none
module ccs_osc_model (
  // control and clocks
  input wire logic hf_run,
  output logic     hf = 1'b0,
  output logic     lf = 1'b0,
  output logic     ext = 1'b0
);
  always #25 if (hf_run) hf = ~hf;
  always #103 lf = ~lf;
  always #41 ext = ~ext;
endmodule
`default_nettype wire

// file: test/ccs_clock_ctrl_test.sv
// self-checking bench for the clock controller
`timescale 1ns/1ns
`default_nettype none
`include "ccs_consts.svh"
module ccs_clock_ctrl_test;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, hf_run, hf, lf, ext, lk, xen;
  logic crystal_fault, high_freq_oscillator_fault, crystal_enable, osc_fault_irq_flag, power_up_clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, sd;
  logic [3:0] pstrb, st;
  ccs_pkg::ccs_trio_s clock_off, clock_request, clock_out;
  logic [15:0] mdl [7];
  logic [15:0] rst [7] = '{{`CCS_KEY_READ, 8'h00}, 16'h0, `CCS_SRC_RESET, `CCS_DIV_RESET,
    `CCS_XOFF_RESET, `CCS_FAULT_RESET, `CCS_REQ_RESET};
  logic [15:0] msk [7] = '{16'h0, 16'h0, `CCS_SRC_MASK, `CCS_DIV_MASK, `CCS_XOFF_MASK,
    `CCS_FAULT_MASK, `CCS_REQ_MASK};
  int n_errors, compares, n_puc, n_exp, cyc, c [6];
  ccs_osc_model osc (.hf_run, .hf, .lf, .ext);
  ccs_clock_ctrl dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .high_freq_clock(hf), .low_freq_clock(lf),
    .external_clock_input(ext), .crystal_fault, .high_freq_oscillator_fault, .clock_off, .clock_request,
    .clock_out, .crystal_enable, .osc_fault_irq_flag, .power_up_clear);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    n_puc += int'(power_up_clear === 1'b1);
    cyc++;
    if (cyc > 60000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic check_rate(input int g, input int e);
    compares++;
    if (g > e + 2 || g + 2 < e) begin
      n_errors++;
      $display("CHECK FAILED %0t edges %0d exp %0d", $time, g, e);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic boot();
    mdl = rst;
    lk = 1'b1;
    n_exp++;
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d = 16'h0,
    input logic [3:0] s = 4'h3);
    int i;
    logic ok;
    logic [15:0] m;
    i = int'(a[11:2]);
    ok = i < 7 && i != 1;
    m = {{8{s[1]}}, {8{s[0]}}} & (ok ? msk[i] : 16'h0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {sd[31:16], d};
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int t = 0; t < 9 && pready !== 1'b1; t++) @(posedge core_clk);
    check({31'h0, pready}, 32'h1);
    if (!w && i == 5) mdl[5] = mdl[5] | {14'h0, crystal_fault, high_freq_oscillator_fault};
    if (!w) check(prdata, {16'h0, ok ? mdl[i] : 16'h0});
    check({31'h0, pslverr}, {31'h0, !ok});
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && i == 0 && s[1]) begin
      if (d[15:8] == `CCS_KEY_VALUE) lk = 1'b0;
      else if (s[0]) boot();
      else lk = 1'b1;
    end else if (w && ok && lk) boot();
    else if (w && ok) mdl[i] = mdl[i] & ~m | d & m;
    @(posedge core_clk);
  endtask
  task automatic meas();
    logic [5:0] p;
    logic [5:0] v;
    p = 6'h0;
    c = '{default: 0};
    repeat (1500) begin
      @(posedge core_clk);
      v = {clock_out, hf, lf, ext};
      for (int i = 0; i < 6; i++) c[i] += int'(v[i] & ~p[i]);
      p = v;
    end
  endtask
  task automatic rate(input int m, input int k, input int s, input int x);
    int d;
    d = 1 << (k > 5 ? 5 : k);
    acc(1'b1, 12'h008, 16'(m) * 16'h0011 + 16'(m == 3 ? 1 : m) * 16'h0100);
    acc(1'b1, 12'h00C, 16'(k) * 16'h0111);
    repeat (400) @(posedge core_clk);
    meas();
    for (int i = 3; i < 6; i++) check_rate(c[i], c[s] / d * x);
  endtask
  initial begin
    {psel, penable, pwrite, crystal_fault, high_freq_oscillator_fault, nrst} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    clock_off = 3'h0;
    clock_request = 3'h0;
    hf_run = 1'b1;
    sd = 32'hD74F;
    mdl = rst;
    lk = 1'b1;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) acc(1'b0, 12'(i * 4));
    acc(1'b1, 12'h000, 16'hA500);
    acc(1'b1, 12'h014, 16'h0);
    for (int k = 0; k < 6; k++) begin
      for (int a = 8; a < 32; a += 4) begin
        sd = lfsr(sd);
        st = 4'(sd[5:4] == 2'h0 ? 2'h3 : sd[5:4]);
        if (a != 20) acc(1'b1, 12'(a), sd[15:0], st);
        acc(1'b0, 12'(a));
      end
      xen = !mdl[4][0] || mdl[2][1:0] == 2'h2 || mdl[2][5:4] == 2'h2 || mdl[2][9:8] == 2'h2;
      check({31'h0, crystal_enable}, {31'h0, xen});
    end
    for (int b = 1; b < 5; b++) begin
      {crystal_fault, high_freq_oscillator_fault} <= b[1:0] & {2{~b[2]}};
      repeat (10) @(posedge core_clk);
      acc(1'b1, 12'h014, 16'h0);
      acc(1'b0, 12'h014);
      check({31'h0, osc_fault_irq_flag}, {31'h0, |mdl[5]});
    end
    acc(1'b1, 12'h018, 16'h0007);
    for (int k = 0; k < 8; k++) rate(0, k, 2, 1);
    for (int m = 1; m < 4; m++) rate(m, 0, m == 2 ? 0 : 1, 1);
    clock_off <= 3'h7;
    rate(0, 0, 2, 0);
    clock_request <= 3'h7;
    rate(0, 0, 2, 1);
    acc(1'b1, 12'h018, 16'h0);
    rate(0, 0, 2, 0);
    clock_off <= 3'h0;
    hf_run <= 1'b0;
    rate(0, 0, 1, 1);
    acc(1'b1, 12'h000, 16'h0000, 4'h2);
    acc(1'b1, 12'h008, 16'h0002);
    acc(1'b0, 12'h008);
    acc(1'b1, 12'h000, 16'hA500);
    acc(1'b1, 12'h000, 16'h1200);
    acc(1'b0, 12'h00C);
    check(32'(n_puc), 32'(n_exp));
    results();
  end
endmodule
`default_nettype wire
